// file: rtl/mbmd_defs.svh
// address map constants, masks and strap codes for the bus matrix decoder
`ifndef MBMD_DEFS_SVH
`define MBMD_DEFS_SVH
// -----------------------------------------------------------------
// segment numbers, taken from address bits 31:28
// -----------------------------------------------------------------
`define MBMD_SEG_LOW 4'h0
`define MBMD_SEG_SWITCH 4'h1
`define MBMD_SEG_SDRAM 4'h2
`define MBMD_SEG_IO 4'h3
`define MBMD_SEG_BRIDGE 4'h4
`define MBMD_SEG_INTC 4'h5
`define MBMD_SEG_EMREG 4'h7
`define MBMD_SEG_DMA 4'h8
// -----------------------------------------------------------------
// mirror masks and window limits
// -----------------------------------------------------------------
`define MBMD_SDRAM_MASK 32'h07ff_ffff
`define MBMD_STATIC_MASK 32'h03ff_ffff
`define MBMD_BANK_MASK 32'h00ff_ffff
`define MBMD_ROM_MASK 32'h0000_1fff
`define MBMD_INTC_MASK 32'h0000_007f
`define MBMD_SW_MIRROR 32'h007f_ffff
`define MBMD_SW_COMM 7'h10
`define MBMD_PER_BASE 28'h000_2000
`define MBMD_PER_LIMIT 28'h000_2800
`define MBMD_ICACHE_TOP 32'h0000_0fff
// -----------------------------------------------------------------
// low segment strap codes and bus transfer codes
// -----------------------------------------------------------------
`define MBMD_BOOT_INT 2'h0
`define MBMD_BOOT_SDRAM 2'h1
`define MBMD_HTRANS_IDLE 2'h0
`define MBMD_HTRANS_NONSEQ 2'h2
`endif

// file: rtl/mbmd_pkg.sv
// types and shared helpers of the bus matrix decoder
package mbmd_pkg;
    typedef enum logic [1:0] {
        MS_CPU = 2'h0, MS_RTS = 2'h1, MS_LHB = 2'h2, MS_DMA = 2'h3
    } mbmd_master_t;
    typedef enum logic [2:0] {
        SL_BRIDGE = 3'h0, SL_EXTMEM = 3'h1, SL_DMA = 3'h2, SL_SWITCH = 3'h3, SL_INTC = 3'h4
    } mbmd_slave_t;
    typedef enum logic [3:0] {
        RG_NONE = 4'h0, RG_ROM = 4'h1, RG_SRAM = 4'h2, RG_SDRAM = 4'h3,
        RG_BANK0 = 4'h4, RG_BANK1 = 4'h5, RG_BANK2 = 4'h6, RG_BANK3 = 4'h7,
        RG_STATIC = 4'h8, RG_EMREG = 4'h9, RG_SWREG = 4'ha, RG_SWCOMM = 4'hb,
        RG_GAP = 4'hc, RG_PER = 4'hd, RG_INTC = 4'he, RG_DMA = 4'hf
    } mbmd_region_t;
    typedef struct packed {
        logic ok;
        mbmd_slave_t slv;
        mbmd_region_t rg;
        logic [31:0] addr;
    } mbmd_dec_t;
    // priority rank of a master, 0 is highest
    function automatic logic [1:0] mbmd_rank(input logic [1:0] m);
        case (m)
            2'h0: mbmd_rank = 2'h0;
            2'h1: mbmd_rank = 2'h1;
            2'h3: mbmd_rank = 2'h2;
            default: mbmd_rank = 2'h3;
        endcase
    endfunction
endpackage

// file: rtl/mbmd_layer.sv
// one slave layer: arbiter plus registered slave port
`timescale 1ns/1ns
`include "mbmd_defs.svh"
module mbmd_layer
    import mbmd_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // requests from master ports
    input wire logic [3:0] req,
    input wire logic [3:0][31:0] m_addr,
    input wire logic [3:0] m_write,
    input wire logic [3:0][2:0] m_size,
    input wire logic [3:0][3:0] m_region,
    input wire logic [3:0][31:0] m_wdata,
    input wire logic fixed_prio,
    // answer to master ports
    output logic [3:0] gnt_r,
    output logic done_r,
    output logic err_r,
    output logic [31:0] rdata_r,
    // slave port
    output logic hsel_r,
    output logic [31:0] haddr_r,
    output logic [1:0] htrans_r,
    output logic hwrite_r,
    output logic [2:0] hsize_r,
    output logic [31:0] hwdata_r,
    output logic [3:0] region_r,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata
);
    typedef enum logic [3:0] {
        LY_IDLE = 4'b0001, LY_ADDR = 4'b0010, LY_DATA = 4'b0100, LY_DONE = 4'b1000
    } mbmd_ly_t;
    mbmd_ly_t st_r;
    logic [1:0] last_r;
    logic [1:0] idx_r;
    logic [1:0] pick;
    // -----------------------------------------------------------------
    // choice of next master
    // -----------------------------------------------------------------
    always_comb begin
        logic [1:0] c;
        logic [1:0] best;
        c = 2'h0;
        best = 2'h3;
        pick = 2'h0;
        if (fixed_prio) begin
            for (int i = 3; i >= 0; i--) begin
                c = 2'(i);
                if (req[c] && mbmd_rank(c) <= best) begin
                    best = mbmd_rank(c);
                    pick = c;
                end
            end
        end else begin
            for (int k = 4; k >= 1; k--) begin
                c = 2'(last_r + 2'(k));
                if (req[c]) begin
                    pick = c;
                end
            end
        end
    end
    // -----------------------------------------------------------------
    // transfer sequence on the slave port
    // -----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= LY_IDLE;
            gnt_r <= 4'h0;
            idx_r <= 2'h0;
            last_r <= 2'h3;
            done_r <= 1'b0;
            err_r <= 1'b0;
            rdata_r <= 32'h0;
            hsel_r <= 1'b0;
            haddr_r <= 32'h0;
            htrans_r <= `MBMD_HTRANS_IDLE;
            hwrite_r <= 1'b0;
            hsize_r <= 3'h0;
            region_r <= 4'h0;
        end else begin
            case (st_r)
                LY_IDLE: begin
                    if (|req) begin
                        gnt_r <= 4'h1 << pick;
                        idx_r <= pick;
                        last_r <= pick;
                        hsel_r <= 1'b1;
                        htrans_r <= `MBMD_HTRANS_NONSEQ;
                        haddr_r <= m_addr[pick];
                        hwrite_r <= m_write[pick];
                        hsize_r <= m_size[pick];
                        region_r <= m_region[pick];
                        st_r <= LY_ADDR;
                    end
                end
                LY_ADDR: begin
                    hsel_r <= 1'b0;
                    htrans_r <= `MBMD_HTRANS_IDLE;
                    st_r <= LY_DATA;
                end
                LY_DATA: begin
                    if (hreadyout) begin
                        done_r <= 1'b1;
                        err_r <= hresp;
                        rdata_r <= hrdata;
                        st_r <= LY_DONE;
                    end
                end
                LY_DONE: begin
                    done_r <= 1'b0;
                    err_r <= 1'b0;
                    gnt_r <= 4'h0;
                    st_r <= LY_IDLE;
                end
                default: st_r <= LY_IDLE;
            endcase
        end
    end
    // write data of the granted master
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            hwdata_r <= 32'h0;
        end else begin
            hwdata_r <= m_wdata[idx_r];
        end
    end
endmodule

// file: rtl/mbmd_matrix.sv
// multilayer bus matrix with per-master address decoding
// Behaviour
// - 32-bit transfers on every bus port
// - independent layer per slave, parallel transfers
// - per-slave arbiter, round robin by default
// - optional fixed priority cpu, switch, dma, host
// - limited master to slave connectivity
// - same-address collision captures higher-priority attributes
// - bridge slave port carries peripheral traffic
// - sixteen 256 MB segments, 6 and 9-15 unused
// - processor segment map 0-5, 7, 8
// - switch master sees segments 2-3 only, and 0 when not strapped to boot rom
// - host decodes 0-4, 7; dma 0, 2-4
// - segment 3 four 16 MB banks, rest unused
// - sdram mirrored over 128 MB
// - switch registers and 64 kB communication memory
// - bridge boot rom then eight 256-byte windows
// - low segment boot rom, sram after swap
// - cache overlay up to 0000 0fff processor only
// - low segment content from reset strap
// - interrupt controller 128 bytes mirrored
// - gaps in mirrors raise no error
// - 2 MB switch block repeats every 8 MB
`timescale 1ns/1ns
`include "mbmd_defs.svh"
module mbmd_matrix
    import mbmd_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // configuration levels
    input wire logic fixed_prio,
    input wire logic mem_swap,
    input wire logic icache_overlay,
    input wire logic [1:0] boot_strap,
    // master ports, index 0 cpu, 1 switch, 2 host bus unit, 3 dma
    input wire logic [3:0][31:0] m_haddr,
    input wire logic [3:0][1:0] m_htrans,
    input wire logic [3:0] m_hwrite,
    input wire logic [3:0][2:0] m_hsize,
    input wire logic [3:0][31:0] m_hwdata,
    output logic [3:0] m_hready_r,
    output logic [3:0] m_hresp_r,
    output logic [3:0][31:0] m_hrdata_r,
    // slave ports, index 0 bridge, 1 ext memory, 2 dma, 3 switch, 4 irq ctrl
    output logic [4:0] s_hsel_r,
    output logic [4:0][31:0] s_haddr_r,
    output logic [4:0][1:0] s_htrans_r,
    output logic [4:0] s_hwrite_r,
    output logic [4:0][2:0] s_hsize_r,
    output logic [4:0][31:0] s_hwdata_r,
    output logic [4:0][3:0] s_region_r,
    input wire logic [4:0] s_hreadyout,
    input wire logic [4:0] s_hresp,
    input wire logic [4:0][31:0] s_hrdata,
    // collision capture
    output logic clash_seen_r,
    output logic [1:0] clash_master_r,
    output logic [31:0] clash_addr_r,
    output logic clash_write_r,
    output logic [2:0] clash_size_r
);
    typedef enum logic [2:0] {
        MP_OPEN = 3'b001, MP_WAIT = 3'b010, MP_ERR = 3'b100
    } mbmd_mp_t;

    // -----------------------------------------------------------------
    // connectivity
    // -----------------------------------------------------------------
    function automatic logic reach(input logic [1:0] m, input mbmd_slave_t s);
        case (m)
            MS_CPU: reach = 1'b1;
            MS_RTS: reach = (s == SL_EXTMEM);
            MS_DMA: reach = (s == SL_EXTMEM) || (s == SL_BRIDGE);
            default: reach = (s == SL_EXTMEM) || (s == SL_BRIDGE) || (s == SL_SWITCH);
        endcase
    endfunction

    // -----------------------------------------------------------------
    // address decoder, one view per master
    // -----------------------------------------------------------------
    function automatic mbmd_dec_t decode(input logic [1:0] m, input logic [31:0] a,
                                         input logic swap, input logic [1:0] boot,
                                         input logic ovl);
        mbmd_dec_t d;
        d.ok = 1'b0;
        d.slv = SL_BRIDGE;
        d.rg = RG_NONE;
        d.addr = a;
        case (a[31:28])
            `MBMD_SEG_LOW: begin
                if (ovl && m == MS_CPU && a <= `MBMD_ICACHE_TOP) begin
                    d.ok = 1'b0;
                end else if (boot == `MBMD_BOOT_INT) begin
                    d.ok = 1'b1;
                    d.rg = swap ? RG_SRAM : RG_ROM;
                    d.addr = a & `MBMD_ROM_MASK;
                end else if (boot == `MBMD_BOOT_SDRAM) begin
                    d.ok = 1'b1;
                    d.slv = SL_EXTMEM;
                    d.rg = RG_SDRAM;
                    d.addr = a & `MBMD_SDRAM_MASK;
                end else begin
                    d.ok = 1'b1;
                    d.slv = SL_EXTMEM;
                    d.rg = RG_STATIC;
                    d.addr = a & `MBMD_STATIC_MASK;
                end
            end
            `MBMD_SEG_SWITCH: begin
                d.ok = (m != MS_DMA);
                d.slv = SL_SWITCH;
                // 2 MB block every 8 MB
                d.addr = a & `MBMD_SW_MIRROR;
                if (a[22:20] == 3'h0) begin
                    d.rg = RG_SWREG;
                end else if (a[22:16] == `MBMD_SW_COMM) begin
                    d.rg = RG_SWCOMM;
                end else begin
                    d.rg = RG_GAP;
                end
            end
            `MBMD_SEG_SDRAM: begin
                d.ok = 1'b1;
                d.slv = SL_EXTMEM;
                d.rg = RG_SDRAM;
                d.addr = a & `MBMD_SDRAM_MASK;
            end
            `MBMD_SEG_IO: begin
                d.ok = (a[27:26] == 2'h0);
                d.slv = SL_EXTMEM;
                d.addr = a & `MBMD_BANK_MASK;
                case (a[25:24])
                    2'h0: d.rg = RG_BANK0;
                    2'h1: d.rg = RG_BANK1;
                    2'h2: d.rg = RG_BANK2;
                    default: d.rg = RG_BANK3;
                endcase
            end
            `MBMD_SEG_BRIDGE: begin
                d.ok = (m != MS_RTS) && (a[27:0] < `MBMD_PER_LIMIT);
                d.slv = SL_BRIDGE;
                d.rg = (a[27:0] < `MBMD_PER_BASE) ? RG_ROM : RG_PER;
            end
            `MBMD_SEG_INTC: begin
                d.ok = (m == MS_CPU);
                d.slv = SL_INTC;
                d.rg = RG_INTC;
                d.addr = a & `MBMD_INTC_MASK;
            end
            `MBMD_SEG_EMREG: begin
                d.ok = (m == MS_CPU) || (m == MS_LHB);
                d.slv = SL_EXTMEM;
                d.rg = RG_EMREG;
            end
            `MBMD_SEG_DMA: begin
                d.ok = (m == MS_CPU);
                d.slv = SL_DMA;
                d.rg = RG_DMA;
            end
            default: d.ok = 1'b0;
        endcase
        d.ok = d.ok && reach(m, d.slv);
        decode = d;
    endfunction

    // -----------------------------------------------------------------
    // strap capture after reset release
    // -----------------------------------------------------------------
    logic [1:0] boot_cfg_r;
    logic cfg_taken_r;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            boot_cfg_r <= `MBMD_BOOT_INT;
            cfg_taken_r <= 1'b0;
        end else if (!cfg_taken_r) begin
            boot_cfg_r <= boot_strap;
            cfg_taken_r <= 1'b1;
        end
    end

    // -----------------------------------------------------------------
    // shared signals between master ports and layers
    // -----------------------------------------------------------------
    logic [3:0] take;
    mbmd_dec_t dec [4];
    mbmd_mp_t mp_r [4];
    logic [3:0][2:0] tgt_r;
    logic [3:0][31:0] q_addr_r;
    logic [3:0] q_write_r;
    logic [3:0][2:0] q_size_r;
    logic [3:0][3:0] q_region_r;
    logic [4:0][3:0] req;
    logic [4:0][3:0] gnt;
    logic [4:0] ly_done;
    logic [4:0] ly_err;
    logic [4:0][31:0] ly_rdata;

    // -----------------------------------------------------------------
    // master ports
    // -----------------------------------------------------------------
    genvar gm;
    generate
        for (gm = 0; gm < 4; gm++) begin : g_mport
            logic [2:0] t;
            logic fin;
            assign t = tgt_r[gm];
            assign fin = (t < 3'h5) && ly_done[t] && gnt[t][gm];
            assign take[gm] = m_hready_r[gm] && m_htrans[gm][1];
            always_comb begin
                dec[gm] = decode(2'(gm), m_haddr[gm], mem_swap, boot_cfg_r,
                                 icache_overlay);
            end
            always_ff @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n) begin
                    mp_r[gm] <= MP_OPEN;
                    m_hready_r[gm] <= 1'b1;
                    m_hresp_r[gm] <= 1'b0;
                    m_hrdata_r[gm] <= 32'h0;
                    tgt_r[gm] <= 3'h0;
                    q_addr_r[gm] <= 32'h0;
                    q_write_r[gm] <= 1'b0;
                    q_size_r[gm] <= 3'h0;
                    q_region_r[gm] <= 4'h0;
                end else begin
                    case (mp_r[gm])
                        MP_OPEN: begin
                            m_hresp_r[gm] <= 1'b0;
                            if (take[gm]) begin
                                m_hready_r[gm] <= 1'b0;
                                q_addr_r[gm] <= dec[gm].addr;
                                q_write_r[gm] <= m_hwrite[gm];
                                q_size_r[gm] <= m_hsize[gm];
                                q_region_r[gm] <= dec[gm].rg;
                                tgt_r[gm] <= dec[gm].slv;
                                if (dec[gm].ok) begin
                                    mp_r[gm] <= MP_WAIT;
                                end else begin
                                    m_hresp_r[gm] <= 1'b1;
                                    mp_r[gm] <= MP_ERR;
                                end
                            end
                        end
                        MP_WAIT: begin
                            if (fin) begin
                                m_hrdata_r[gm] <= ly_rdata[t];
                                if (ly_err[t]) begin
                                    m_hresp_r[gm] <= 1'b1;
                                    mp_r[gm] <= MP_ERR;
                                end else begin
                                    m_hready_r[gm] <= 1'b1;
                                    mp_r[gm] <= MP_OPEN;
                                end
                            end
                        end
                        MP_ERR: begin
                            // second cycle of the error answer
                            m_hready_r[gm] <= 1'b1;
                            m_hresp_r[gm] <= 1'b1;
                            mp_r[gm] <= MP_OPEN;
                        end
                        default: begin
                            m_hready_r[gm] <= 1'b1;
                            mp_r[gm] <= MP_OPEN;
                        end
                    endcase
                end
            end
        end
    endgenerate

    // -----------------------------------------------------------------
    // one layer per slave
    // -----------------------------------------------------------------
    genvar gs;
    generate
        for (gs = 0; gs < 5; gs++) begin : g_layer
            always_comb begin
                for (int i = 0; i < 4; i++) begin
                    req[gs][i] = (mp_r[i] == MP_WAIT) && (tgt_r[i] == 3'(gs));
                end
            end
            mbmd_layer u_layer (
                .ref_clk(ref_clk),
                .reset_n(reset_n),
                .req(req[gs]),
                .m_addr(q_addr_r),
                .m_write(q_write_r),
                .m_size(q_size_r),
                .m_region(q_region_r),
                .m_wdata(m_hwdata),
                .fixed_prio(fixed_prio),
                .gnt_r(gnt[gs]),
                .done_r(ly_done[gs]),
                .err_r(ly_err[gs]),
                .rdata_r(ly_rdata[gs]),
                .hsel_r(s_hsel_r[gs]),
                .haddr_r(s_haddr_r[gs]),
                .htrans_r(s_htrans_r[gs]),
                .hwrite_r(s_hwrite_r[gs]),
                .hsize_r(s_hsize_r[gs]),
                .hwdata_r(s_hwdata_r[gs]),
                .region_r(s_region_r[gs]),
                .hreadyout(s_hreadyout[gs]),
                .hresp(s_hresp[gs]),
                .hrdata(s_hrdata[gs])
            );
        end
    endgenerate

    // -----------------------------------------------------------------
    // same-address collision capture
    // -----------------------------------------------------------------
    logic clash;
    logic [1:0] clash_win;
    always_comb begin
        logic [1:0] w;
        w = 2'h0;
        clash = 1'b0;
        clash_win = 2'h0;
        for (int i = 0; i < 4; i++) begin
            for (int j = i + 1; j < 4; j++) begin
                if (take[i] && take[j] && m_haddr[i] == m_haddr[j]) begin
                    w = (mbmd_rank(2'(i)) < mbmd_rank(2'(j))) ? 2'(i) : 2'(j);
                    if (!clash || mbmd_rank(w) < mbmd_rank(clash_win)) begin
                        clash_win = w;
                    end
                    clash = 1'b1;
                end
            end
        end
    end
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            clash_seen_r <= 1'b0;
            clash_master_r <= 2'h0;
            clash_addr_r <= 32'h0;
            clash_write_r <= 1'b0;
            clash_size_r <= 3'h0;
        end else begin
            clash_seen_r <= clash;
            if (clash) begin
                clash_master_r <= clash_win;
                clash_addr_r <= m_haddr[clash_win];
                clash_write_r <= m_hwrite[clash_win];
                clash_size_r <= m_hsize[clash_win];
            end
        end
    end
endmodule

// file: tb/mbmd_checker.sv
// port assertions of the bus matrix
`timescale 1ns/1ns
module mbmd_checker (
    // watched ports
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [3:0][31:0] m_haddr,
    input wire logic [3:0][1:0] m_htrans,
    input wire logic [3:0] m_hready_r,
    input wire logic [3:0] m_hresp_r,
    input wire logic [4:0] s_hsel_r,
    input wire logic [4:0][1:0] s_htrans_r,
    input wire logic clash_seen_r,
    input wire logic [1:0] clash_master_r
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    logic [3:0] tk;
    assign tk = m_hready_r & {m_htrans[3][1], m_htrans[2][1], m_htrans[1][1], m_htrans[0][1]};
    take_drop_a: assert property (tk[0] |=> !m_hready_r[0])
        else $error("ready stayed high");
    err_pair_a: assert property (m_hresp_r[0] && !m_hready_r[0] |=> m_hresp_r[0] && m_hready_r[0])
        else $error("error answer not two cycles");
    seg_unused_a: assert property (tk[0] && m_haddr[0][31:28] > 4'h8 |=> m_hresp_r[0])
        else $error("unused segment not refused");
    sw_reach_a: assert property (tk[1] && m_haddr[1][31:28] > 4'h3 |=> m_hresp_r[1])
        else $error("switch master reached a slave");
    dma_reach_a: assert property (tk[3] && m_haddr[3][31:28] == 4'h1 |=> m_hresp_r[3])
        else $error("dma reached switch");
    sdram_wait_a: assert property (tk[0] && m_haddr[0][31:28] == 4'h2 |=> (!m_hready_r[0])[*4])
        else $error("sdram access too short");
    addr_phase_a: assert property (s_hsel_r[1] |-> s_htrans_r[1] == 2'h2 ##1 !s_hsel_r[1])
        else $error("bad address phase");
    clash_cap_a: assert property (tk[0] && tk[3] && m_haddr[0] == m_haddr[3]
        |=> clash_seen_r && clash_master_r == 2'h0)
        else $error("clash not captured");
    cover property (tk[0] && tk[3]);
    cover property (m_hresp_r[1]);
    cover property (clash_seen_r);
endmodule
bind mbmd_matrix mbmd_checker chk (.*);

// file: tb/mbmd_slave_model.sv
// slave with programmable wait states
`timescale 1ns/1ns
module mbmd_slave_model (
    // bus side
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [7:0] waits,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);
    logic busy_r;
    logic [7:0] cnt_r;
    logic [31:0] addr_r;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_r <= 1'b0;
            cnt_r <= 8'h00;
            addr_r <= 32'h0000_0000;
        end else if (hsel) begin
            busy_r <= 1'b1;
            cnt_r <= waits;
            addr_r <= haddr;
        end else if (busy_r && cnt_r == 8'h00) begin
            busy_r <= 1'b0;
        end else if (busy_r) begin
            cnt_r <= cnt_r - 8'h01;
        end
    end
    assign hreadyout = !busy_r || cnt_r == 8'h00;
    assign hresp = busy_r && cnt_r == 8'h00 && addr_r[11:0] == 12'heee;
    assign hrdata = (busy_r && cnt_r == 8'h00) ? addr_r ^ 32'h5a5a_5a5a : ~addr_r;
endmodule

// file: tb/mbmd_matrix_tb.sv
// self-checking bench of the bus matrix
`timescale 1ns/1ns
module mbmd_matrix_tb;
    typedef struct {int m; logic [31:0] a; logic e; logic [2:0] s; logic [31:0] sa;} mbmd_row_t;
    logic ref_clk = 1'b0, reset_n = 1'b0, fixed_prio = 1'b0, icache_overlay = 1'b0;
    logic [7:0] lat = 8'h00;
    logic [3:0][31:0] m_haddr = '0, m_hrdata_r;
    logic [3:0][1:0] m_htrans = '0;
    logic [3:0] m_hready_r, m_hresp_r;
    logic [4:0] s_hsel_r, s_hreadyout, s_hresp;
    logic [4:0][31:0] s_haddr_r, s_hrdata;
    logic clash_seen_r, clash_hit = 1'b0, e, e0, e1;
    logic [1:0] clash_master_r;
    logic [2:0] sl;
    logic [31:0] d, ca;
    time t0, t1;
    int n_fail = 0, checks = 0;
    mbmd_row_t rows [12] = '{'{0, 32'h9000_0000, 1, 7, 0}, '{0, 32'h5000_0084, 0, 4, 32'h4},
        '{0, 32'h3400_0000, 1, 7, 0}, '{0, 32'h4000_2800, 1, 7, 0},
        '{0, 32'h4000_2104, 0, 0, 32'h4000_2104}, '{0, 32'h8000_0000, 0, 2, 32'h8000_0000},
        '{0, 32'h1080_0004, 0, 3, 32'h4}, '{1, 32'h4000_2000, 1, 7, 0}, '{3, 32'h1000_0000, 1, 7, 0},
        '{0, 32'h2000_0eee, 1, 1, 0}, '{1, 32'h2800_0008, 0, 1, 32'h8},
        '{2, 32'h7000_0000, 0, 1, 32'h7000_0000}};
    always #25 ref_clk = ~ref_clk;
    mbmd_matrix DUT (.ref_clk, .reset_n, .fixed_prio, .mem_swap(1'b0), .icache_overlay,
        .boot_strap(2'h0), .m_haddr, .m_htrans, .m_hwrite(4'h0), .m_hsize(12'h000),
        .m_hwdata(128'h0), .m_hready_r, .m_hresp_r, .m_hrdata_r, .s_hsel_r, .s_haddr_r,
        .s_htrans_r(), .s_hwrite_r(), .s_hsize_r(), .s_hwdata_r(), .s_region_r(), .s_hreadyout,
        .s_hresp, .s_hrdata, .clash_seen_r, .clash_master_r, .clash_addr_r(ca), .clash_write_r(),
        .clash_size_r());
    for (genvar i = 0; i < 5; i++) begin : g_slv
        mbmd_slave_model u_slv (.ref_clk, .reset_n, .hsel(s_hsel_r[i]), .haddr(s_haddr_r[i]),
            .waits(lat), .hreadyout(s_hreadyout[i]), .hresp(s_hresp[i]), .hrdata(s_hrdata[i]));
    end
    always @(posedge ref_clk) begin
        if (clash_seen_r)
            clash_hit <= 1'b1;
        for (int i = 0; i < 4; i++)
            if (m_htrans[i][1])
                sl <= 3'h7;
        for (int i = 0; i < 5; i++)
            if (s_hsel_r[i])
                sl <= 3'(i);
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic xfer(input int m, input logic [31:0] a, output logic er, output time t);
        int k;
        @(posedge ref_clk);
        m_haddr[m] <= a;
        m_htrans[m] <= 2'h2;
        @(posedge ref_clk);
        m_htrans[m] <= 2'h0;
        for (k = 0; k < 60; k++) begin
            @(posedge ref_clk);
            #1;
            if (m_hready_r[m] === 1'b1)
                break;
        end
        if (k == 60) begin
            n_fail++;
            summarize();
        end
        er = m_hresp_r[m];
        d = m_hrdata_r[m];
        t = $time;
    endtask
    initial begin
        repeat (4) @(posedge ref_clk);
        check(32'(m_hready_r), 32'hf);
        reset_n <= 1'b1;
        foreach (rows[i]) begin
            xfer(rows[i].m, rows[i].a, e, t0);
            check(32'(e), 32'(rows[i].e));
            check(32'(sl), 32'(rows[i].s));
            if (!rows[i].e)
                check(d, rows[i].sa ^ 32'h5a5a_5a5a);
        end
        $display("decode rows done");
        icache_overlay <= 1'b1;
        xfer(0, 32'h0000_0100, e, t0);
        check(32'(e), 32'h1);
        lat <= 8'h03;
        fork
            xfer(0, 32'h2000_0100, e0, t0);
            xfer(3, 32'h2000_0100, e1, t1);
        join
        check(32'(t1 < t0), 32'h1);
        check({clash_hit, 29'h0, clash_master_r}, 32'h8000_0000);
        check(ca, 32'h2000_0100);
        fixed_prio <= 1'b1;
        fork
            xfer(0, 32'h2000_0200, e0, t0);
            xfer(2, 32'h2000_0300, e1, t1);
        join
        check(32'(t0 < t1), 32'h1);
        $display("arbitration done");
        summarize();
    end
endmodule
